// ### hw/shift_rotate_pkg.sv
package shift_rotate_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DEST_OFS = 8'h04;
  localparam logic [7:0] SECOND_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  localparam logic [7:0] FLAGS_OFS = 8'h10;
  localparam logic [7:0] RESULT_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;

  localparam int COUNT_BITS = 5;
  localparam int STEPS = 31;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] WORD_BITS = 6'h10;
  localparam logic [5:0] DWORD_BITS = 6'h20;
  localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;
  localparam logic [31:0] WORD_MASK = 32'h0000_ffff;
  localparam logic [31:0] DWORD_MASK = 32'hffff_ffff;

  typedef enum logic [4:0] {
    OP_ARITH_LEFT_SHIFT = 5'h00,
    OP_LOGIC_LEFT_SHIFT = 5'h01,
    OP_ARITH_RIGHT_SHIFT = 5'h02,
    OP_LOGIC_RIGHT_SHIFT = 5'h03,
    OP_DOUBLE_LEFT_SHIFT = 5'h04,
    OP_DOUBLE_RIGHT_SHIFT = 5'h05,
    OP_ROTATE_LEFT = 5'h06,
    OP_ROTATE_RIGHT = 5'h07,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h08,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h09,
    OP_BIT_PROBE = 5'h0a,
    OP_BIT_PROBE_AND_SET = 5'h0b,
    OP_BIT_PROBE_AND_CLEAR = 5'h0c,
    OP_BIT_PROBE_AND_INVERT = 5'h0d,
    OP_SCAN_UP_FIRST_ONE = 5'h0e,
    OP_SCAN_DOWN_FIRST_ONE = 5'h0f,
    OP_CONDITIONAL_BYTE_WRITE = 5'h10
  } op_t;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_DWORD = 2'h2
  } opsize_t;

  // condition codes for the conditional byte write
  typedef enum logic [3:0] {
    COND_OVERFLOW = 4'h0,
    COND_NO_OVERFLOW = 4'h1,
    COND_CARRY = 4'h2,
    COND_NO_CARRY = 4'h3,
    COND_ZERO = 4'h4,
    COND_NOT_ZERO = 4'h5,
    COND_BELOW_EQUAL = 4'h6,
    COND_ABOVE = 4'h7,
    COND_SIGN = 4'h8,
    COND_NO_SIGN = 4'h9,
    COND_PARITY = 4'ha,
    COND_NO_PARITY = 4'hb,
    COND_LESS = 4'hc,
    COND_GREATER_EQUAL = 4'hd,
    COND_LESS_EQUAL = 4'he,
    COND_GREATER = 4'hf
  } cond_t;

  typedef struct packed {
    logic [15:0] pad_hi;
    logic [3:0] cond;
    logic [1:0] pad_mid;
    logic [1:0] size;
    logic [2:0] pad_lo;
    logic [4:0] op;
  } ctrl_t;

  // status_flag_register image, carry_flag in bit 0
  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic parity_flag;
    logic carry_flag;
  } flags_t;

  typedef struct packed {
    logic [29:0] pad;
    logic scan_none;
    logic illegal;
  } status_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic c;
    logic [31:0] a;
    logic [31:0] b;
  } step_t;

  typedef struct packed {
    logic [31:0] result;
    flags_t flags;
    status_t status;
  } exec_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    ctrl_t ctrl;
    logic [31:0] dest;
    logic [31:0] second;
    logic [COUNT_BITS-1:0] count;
    flags_t flags;
    logic [31:0] result;
    status_t status;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage : shift_rotate_pkg

// ### hw/shift_rotate_bit_unit.sv
`timescale 1ns/100ps
module shift_rotate_bit_unit (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O
);

  shift_rotate_pkg::state_t state_q;
  shift_rotate_pkg::state_t state_d;
  shift_rotate_pkg::wb_req_t req;
  shift_rotate_pkg::exec_t exec_res;
  shift_rotate_pkg::ctrl_t ctrl_new;

  // byte-lane merge of a bus write
  function automatic logic [31:0] lane_merge(logic [31:0] old, logic [31:0] dat,
                                             logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  function automatic logic is_left(shift_rotate_pkg::op_t op);
    return op == shift_rotate_pkg::OP_ARITH_LEFT_SHIFT ||
           op == shift_rotate_pkg::OP_LOGIC_LEFT_SHIFT ||
           op == shift_rotate_pkg::OP_DOUBLE_LEFT_SHIFT ||
           op == shift_rotate_pkg::OP_ROTATE_LEFT ||
           op == shift_rotate_pkg::OP_ROTATE_LEFT_VIA_CARRY;
  endfunction : is_left

  // one bit position of any shift or rotate; c is the bit that left last
  function automatic shift_rotate_pkg::step_t step1(shift_rotate_pkg::op_t op,
                                                    logic [4:0] top,
                                                    shift_rotate_pkg::step_t s);
    shift_rotate_pkg::step_t n;
    logic out;
    logic fill;
    n = s;
    fill = 1'b0;
    if (is_left(op)) begin
      out = s.a[top];
      case (op)
        shift_rotate_pkg::OP_DOUBLE_LEFT_SHIFT: fill = s.b[top];
        shift_rotate_pkg::OP_ROTATE_LEFT: fill = out;
        shift_rotate_pkg::OP_ROTATE_LEFT_VIA_CARRY: fill = s.c;
        default: fill = 1'b0;
      endcase
      n.a = {s.a[30:0], fill};
      n.b = {s.b[30:0], 1'b0};
    end else begin
      out = s.a[0];
      case (op)
        shift_rotate_pkg::OP_ARITH_RIGHT_SHIFT: fill = s.a[top];
        shift_rotate_pkg::OP_DOUBLE_RIGHT_SHIFT: fill = s.b[0];
        shift_rotate_pkg::OP_ROTATE_RIGHT: fill = out;
        shift_rotate_pkg::OP_ROTATE_RIGHT_VIA_CARRY: fill = s.c;
        default: fill = 1'b0;
      endcase
      n.a = s.a >> 1;
      n.a[top] = fill;
      n.b = s.b >> 1;
    end
    n.c = out;
    return n;
  endfunction : step1

  function automatic logic cond_holds(logic [3:0] cc, shift_rotate_pkg::flags_t f);
    logic lt;
    logic r;
    lt = f.sign_flag ^ f.overflow_flag;
    case (cc[3:1])
      3'h0: r = f.overflow_flag;
      3'h1: r = f.carry_flag;
      3'h2: r = f.zero_flag;
      3'h3: r = f.carry_flag | f.zero_flag;
      3'h4: r = f.sign_flag;
      3'h5: r = f.parity_flag;
      3'h6: r = lt;
      default: r = lt | f.zero_flag;
    endcase
    return r ^ cc[0];
  endfunction : cond_holds

  function automatic shift_rotate_pkg::exec_t execute(shift_rotate_pkg::ctrl_t c,
                                                      logic [31:0] dst,
                                                      logic [31:0] src,
                                                      logic [4:0] cnt,
                                                      shift_rotate_pkg::flags_t f);
    shift_rotate_pkg::exec_t e;
    shift_rotate_pkg::step_t s;
    shift_rotate_pkg::op_t op;
    logic [5:0] w;
    logic [31:0] m;
    logic [4:0] top;
    logic [4:0] off;
    logic found;
    logic [31:0] idx;
    e.result = dst;
    e.flags = f;
    e.status = '0;
    op = shift_rotate_pkg::op_t'(c.op);
    found = 1'b0;
    idx = 32'h0000_0000;
    case (c.size)
      shift_rotate_pkg::SIZE_BYTE: begin
        w = shift_rotate_pkg::BYTE_BITS;
        m = shift_rotate_pkg::BYTE_MASK;
      end
      shift_rotate_pkg::SIZE_WORD: begin
        w = shift_rotate_pkg::WORD_BITS;
        m = shift_rotate_pkg::WORD_MASK;
      end
      shift_rotate_pkg::SIZE_DWORD: begin
        w = shift_rotate_pkg::DWORD_BITS;
        m = shift_rotate_pkg::DWORD_MASK;
      end
      default: begin
        w = shift_rotate_pkg::DWORD_BITS;
        m = shift_rotate_pkg::DWORD_MASK;
        e.status.illegal = 1'b1;
      end
    endcase
    top = 5'(w - 6'h01);
    off = cnt & top;
    s.c = f.carry_flag;
    s.a = dst & m;
    s.b = src & m;
    if (!e.status.illegal) begin
      case (op)
        shift_rotate_pkg::OP_ARITH_LEFT_SHIFT, shift_rotate_pkg::OP_LOGIC_LEFT_SHIFT,
        shift_rotate_pkg::OP_ARITH_RIGHT_SHIFT, shift_rotate_pkg::OP_LOGIC_RIGHT_SHIFT,
        shift_rotate_pkg::OP_DOUBLE_LEFT_SHIFT, shift_rotate_pkg::OP_DOUBLE_RIGHT_SHIFT,
        shift_rotate_pkg::OP_ROTATE_LEFT, shift_rotate_pkg::OP_ROTATE_RIGHT,
        shift_rotate_pkg::OP_ROTATE_LEFT_VIA_CARRY,
        shift_rotate_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
          if ((op == shift_rotate_pkg::OP_DOUBLE_LEFT_SHIFT ||
               op == shift_rotate_pkg::OP_DOUBLE_RIGHT_SHIFT) &&
              c.size == shift_rotate_pkg::SIZE_BYTE) begin
            e.status.illegal = 1'b1;
          end else begin
            for (int i = 0; i < shift_rotate_pkg::STEPS; i++) begin
              if (5'(i) < cnt) begin
                s = step1(op, top, s);
              end
            end
            // zero count leaves result and carry as they were
            e.flags.carry_flag = s.c;
            e.result = (dst & ~m) | (s.a & m);
          end
        end
        shift_rotate_pkg::OP_BIT_PROBE, shift_rotate_pkg::OP_BIT_PROBE_AND_SET,
        shift_rotate_pkg::OP_BIT_PROBE_AND_CLEAR,
        shift_rotate_pkg::OP_BIT_PROBE_AND_INVERT: begin
          e.flags.carry_flag = dst[off];
          case (op)
            shift_rotate_pkg::OP_BIT_PROBE_AND_SET: e.result[off] = 1'b1;
            shift_rotate_pkg::OP_BIT_PROBE_AND_CLEAR: e.result[off] = 1'b0;
            shift_rotate_pkg::OP_BIT_PROBE_AND_INVERT: e.result[off] = ~dst[off];
            default: e.result = dst;
          endcase
        end
        shift_rotate_pkg::OP_SCAN_UP_FIRST_ONE: begin
          for (int i = 31; i >= 0; i--) begin
            if (6'(i) < w && dst[i]) begin
              found = 1'b1;
              idx = 32'(i);
            end
          end
        end
        shift_rotate_pkg::OP_SCAN_DOWN_FIRST_ONE: begin
          for (int i = 0; i < 32; i++) begin
            if (6'(i) < w && dst[i]) begin
              found = 1'b1;
              idx = 32'(i);
            end
          end
        end
        shift_rotate_pkg::OP_CONDITIONAL_BYTE_WRITE: begin
          e.result = {dst[31:8], 7'h00, cond_holds(c.cond, f)};
        end
        default: e.status.illegal = 1'b1;
      endcase
      if (op == shift_rotate_pkg::OP_SCAN_UP_FIRST_ONE ||
          op == shift_rotate_pkg::OP_SCAN_DOWN_FIRST_ONE) begin
        e.flags.zero_flag = ~found;
        e.status.scan_none = ~found;
        if (found) begin
          e.result = (dst & ~m) | (idx & m);
        end
      end
    end
    return e;
  endfunction : execute

  assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, adr: ADR_I, sel: SEL_I, dat: DAT_I};
  assign ctrl_new = shift_rotate_pkg::ctrl_t'(lane_merge(state_q.ctrl, req.dat, req.sel));
  assign exec_res = execute(ctrl_new, state_q.dest, state_q.second, state_q.count,
                            state_q.flags);

  always_comb begin
    state_d = state_q;
    state_d.ack = req.cyc && req.stb && !state_q.ack;
    // read data is latched with the request, on the same edge that raises ack
    if (req.cyc && req.stb && !state_q.ack) begin
      case (req.adr)
        shift_rotate_pkg::CTRL_OFS: state_d.rdata = state_q.ctrl;
        shift_rotate_pkg::DEST_OFS: state_d.rdata = state_q.dest;
        shift_rotate_pkg::SECOND_OFS: state_d.rdata = state_q.second;
        shift_rotate_pkg::COUNT_OFS: state_d.rdata = {27'h0000000, state_q.count};
        shift_rotate_pkg::FLAGS_OFS: state_d.rdata = {27'h0000000, state_q.flags};
        shift_rotate_pkg::RESULT_OFS: state_d.rdata = state_q.result;
        shift_rotate_pkg::STATUS_OFS: state_d.rdata = state_q.status;
        default: state_d.rdata = shift_rotate_pkg::UNMAPPED_READ;
      endcase
    end
    // writes take effect on the edge that completes the handshake
    if (req.cyc && req.stb && req.we && state_q.ack) begin
      case (req.adr)
        shift_rotate_pkg::CTRL_OFS: begin
          state_d.ctrl = ctrl_new;
          state_d.result = exec_res.result;
          state_d.flags = exec_res.flags;
          state_d.status = exec_res.status;
        end
        shift_rotate_pkg::DEST_OFS: begin
          state_d.dest = lane_merge(state_q.dest, req.dat, req.sel);
        end
        shift_rotate_pkg::SECOND_OFS: begin
          state_d.second = lane_merge(state_q.second, req.dat, req.sel);
        end
        shift_rotate_pkg::COUNT_OFS: begin
          if (req.sel[0]) begin
            state_d.count = req.dat[shift_rotate_pkg::COUNT_BITS-1:0];
          end
        end
        shift_rotate_pkg::FLAGS_OFS: begin
          if (req.sel[0]) begin
            state_d.flags = shift_rotate_pkg::flags_t'(req.dat[4:0]);
          end
        end
        default: state_d.ack = state_d.ack;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state_q <= shift_rotate_pkg::STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign DAT_O = state_q.rdata;
  assign ACK_O = state_q.ack;

endmodule : shift_rotate_bit_unit

// ### tb/shift_rotate_checker.sv
`timescale 1ns/100ps
module shift_rotate_checker (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  wire logic req = CYC_I && STB_I;
  wire logic rd_ack = ACK_O && !WE_I;
  sequence taken_s;
    req && !ACK_O;
  endsequence
  sequence pulse_s;
    ACK_O ##1 !ACK_O;
  endsequence
  ack_pulse_a: assert property (taken_s |=> pulse_s) else $error("ack not one pulse");
  ack_cause_a: assert property (!req |=> !ACK_O) else $error("ack without request");
  rdata_hold_a: assert property (!$past(req) |-> $stable(DAT_O)) else $error("read data moved");
  unmapped_zero_a: assert property (rd_ack && ADR_I > 8'h18 |-> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  count_width_a: assert property (
    rd_ack && ADR_I == shift_rotate_pkg::COUNT_OFS |-> DAT_O[31:5] == 27'h0)
    else $error("count wider than five bits");
  flags_width_a: assert property (rd_ack && ADR_I == shift_rotate_pkg::FLAGS_OFS
    |-> DAT_O[31:5] == 27'h0) else $error("flags upper bits set");
  status_width_a: assert property (rd_ack && ADR_I == shift_rotate_pkg::STATUS_OFS
    |-> DAT_O[31:2] == 30'h0) else $error("status upper bits set");
  quiet_reset_a: assert property ($fell(RESET) |-> !ACK_O && DAT_O == 32'h0)
    else $error("outputs busy after reset");
endmodule : shift_rotate_checker

bind shift_rotate_bit_unit shift_rotate_checker shift_rotate_checker_i (
  .CLOCK(CLOCK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O));

// ### tb/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
  input wire logic CLOCK,
  input wire logic ACK,
  input wire logic [31:0] RDATA,
  output shift_rotate_pkg::wb_req_t REQ
);
  initial REQ = '0;
  // one classic cycle, request held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge CLOCK);
    REQ <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    do @(posedge CLOCK); while (ACK !== 1'b1);
    rd = RDATA;
    REQ <= '0;
  endtask : xfer
endmodule : host_bus_model

// ### tb/shift_rotate_bit_unit_test.sv
`timescale 1ns/100ps
module shift_rotate_bit_unit_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [31:0] dat_o;
  logic ack_o;
  logic [3:0] cc = 4'h0;
  shift_rotate_pkg::wb_req_t req;
  int n_errors = 0;
  int check_count = 0;
  localparam logic [4:0] PATS [4] = '{5'h00, 5'h1f, 5'h09, 5'h14};
  always #4 clock = ~clock;
  host_bus_model host_bus_model_i (.CLOCK(clock), .ACK(ack_o), .RDATA(dat_o), .REQ(req));
  shift_rotate_bit_unit shift_rotate_bit_unit_i (.CLOCK(clock), .RESET(reset),
    .CYC_I(req.cyc), .STB_I(req.stb), .WE_I(req.we), .ADR_I(req.adr), .SEL_I(req.sel),
    .DAT_I(req.dat), .DAT_O(dat_o), .ACK_O(ack_o));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host_bus_model_i.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host_bus_model_i.xfer(1'b0, a, 32'h0, d);
  endtask : rd
  // load operands, execute, compare result and flags
  task automatic ex(input logic [4:0] op, input logic [1:0] sz, input logic [31:0] d,
    input logic [31:0] s, input logic [31:0] n, input logic [4:0] f,
    input logic [31:0] er, input logic [4:0] ef);
    logic [31:0] v;
    wr(shift_rotate_pkg::DEST_OFS, d);
    wr(shift_rotate_pkg::SECOND_OFS, s);
    wr(shift_rotate_pkg::COUNT_OFS, n);
    wr(shift_rotate_pkg::FLAGS_OFS, {27'h0, f});
    wr(shift_rotate_pkg::CTRL_OFS, {16'h0, cc, 2'h0, sz, 3'h0, op});
    rd(shift_rotate_pkg::RESULT_OFS, v);
    check("result", v, er);
    rd(shift_rotate_pkg::FLAGS_OFS, v);
    check("flags", v, {27'h0, ef});
  endtask : ex
  function automatic logic cond_bit(input logic [3:0] c, input logic [4:0] f);
    logic b;
    case (c[3:1])
      3'h0: b = f[4];
      3'h1: b = f[0];
      3'h2: b = f[2];
      3'h3: b = f[0] | f[2];
      3'h4: b = f[3];
      3'h5: b = f[1];
      3'h6: b = f[3] ^ f[4];
      default: b = (f[3] ^ f[4]) | f[2];
    endcase
    return b ^ c[0];
  endfunction : cond_bit
  task automatic t_bus;
    logic [31:0] v;
    for (int a = 0; a < 28; a += 4) begin
      rd(8'(a), v);
      check("reset value", v, 32'h0);
    end
    rd(8'h40, v);
    check("unmapped", v, 32'h0);
    wr(shift_rotate_pkg::RESULT_OFS, 32'hffffffff);
    rd(shift_rotate_pkg::RESULT_OFS, v);
    check("result read only", v, 32'h0);
    wr(shift_rotate_pkg::COUNT_OFS, 32'hffffffff);
    rd(shift_rotate_pkg::COUNT_OFS, v);
    check("count", v, 32'h1f);
  endtask : t_bus
  task automatic t_shift;
    ex(5'h00, 2'h2, 32'h80000001, 32'h0, 32'h1, 5'h00, 32'h2, 5'h01);
    ex(5'h01, 2'h2, 32'h80000001, 32'h0, 32'h1, 5'h00, 32'h2, 5'h01);
    ex(5'h01, 2'h0, 32'h12345681, 32'h0, 32'h1, 5'h00, 32'h12345602, 5'h01);
    ex(5'h00, 2'h1, 32'h3, 32'h0, 32'hf, 5'h00, 32'h8000, 5'h01);
    ex(5'h00, 2'h2, 32'h3, 32'h0, 32'h1f, 5'h00, 32'h80000000, 5'h01);
    ex(5'h01, 2'h2, 32'h40000000, 32'h0, 32'h21, 5'h1f, 32'h80000000, 5'h1e);
    ex(5'h03, 2'h2, 32'h80000003, 32'h0, 32'h1, 5'h00, 32'h40000001, 5'h01);
    ex(5'h03, 2'h1, 32'h8001, 32'h0, 32'hf, 5'h01, 32'h1, 5'h00);
    ex(5'h02, 2'h2, 32'h80000003, 32'h0, 32'h1, 5'h00, 32'hc0000001, 5'h01);
    ex(5'h02, 2'h0, 32'hffffff84, 32'h0, 32'h3, 5'h00, 32'hfffffff0, 5'h01);
    ex(5'h02, 2'h1, 32'h7ff0, 32'h0, 32'h4, 5'h01, 32'h7ff, 5'h00);
  endtask : t_shift
  task automatic t_double;
    logic [31:0] v;
    ex(5'h04, 2'h2, 32'h81234567, 32'hf0000000, 32'h4, 5'h01, 32'h1234567f, 5'h00);
    rd(shift_rotate_pkg::SECOND_OFS, v);
    check("second kept", v, 32'hf0000000);
    ex(5'h04, 2'h1, 32'h55551234, 32'habcd, 32'h8, 5'h00, 32'h555534ab, 5'h00);
    ex(5'h04, 2'h1, 32'habcd, 32'hffff, 32'h0, 5'h01, 32'habcd, 5'h01);
    ex(5'h05, 2'h2, 32'h12345678, 32'hf, 32'h4, 5'h00, 32'hf1234567, 5'h01);
    ex(5'h05, 2'h1, 32'h1234, 32'hf, 32'h4, 5'h01, 32'hf123, 5'h00);
    ex(5'h04, 2'h0, 32'hff, 32'h0, 32'h1, 5'h01, 32'hff, 5'h01);
    rd(shift_rotate_pkg::STATUS_OFS, v);
    check("byte double refused", v, 32'h1);
    ex(5'h00, 2'h3, 32'h5a, 32'h0, 32'h1, 5'h01, 32'h5a, 5'h01);
    rd(shift_rotate_pkg::STATUS_OFS, v);
    check("size refused", v, 32'h1);
    ex(5'h11, 2'h2, 32'h5a, 32'h0, 32'h1, 5'h00, 32'h5a, 5'h00);
    rd(shift_rotate_pkg::STATUS_OFS, v);
    check("opcode refused", v, 32'h1);
    ex(5'h00, 2'h2, 32'h5a, 32'h0, 32'h1, 5'h00, 32'hb4, 5'h00);
    rd(shift_rotate_pkg::STATUS_OFS, v);
    check("status cleared", v, 32'h0);
  endtask : t_double
  task automatic t_rotate;
    ex(5'h06, 2'h2, 32'h80000001, 32'h0, 32'h1, 5'h00, 32'h3, 5'h01);
    ex(5'h07, 2'h2, 32'h80000001, 32'h0, 32'h1, 5'h00, 32'hc0000000, 5'h01);
    ex(5'h06, 2'h0, 32'h81, 32'h0, 32'h4, 5'h01, 32'h18, 5'h00);
    ex(5'h06, 2'h1, 32'h1, 32'h0, 32'h1f, 5'h00, 32'h8000, 5'h00);
    ex(5'h08, 2'h2, 32'h80000000, 32'h0, 32'h1, 5'h00, 32'h0, 5'h01);
    ex(5'h08, 2'h0, 32'h81, 32'h0, 32'h2, 5'h00, 32'h5, 5'h00);
    ex(5'h09, 2'h2, 32'h0, 32'h0, 32'h1, 5'h01, 32'h80000000, 5'h00);
    ex(5'h09, 2'h2, 32'h1, 32'h0, 32'h1, 5'h00, 32'h0, 5'h01);
  endtask : t_rotate
  task automatic t_bits;
    logic [31:0] v;
    ex(5'h0a, 2'h2, 32'h10, 32'h0, 32'h4, 5'h00, 32'h10, 5'h01);
    ex(5'h0b, 2'h2, 32'h0, 32'h0, 32'h1f, 5'h01, 32'h80000000, 5'h00);
    ex(5'h0c, 2'h2, 32'hffffffff, 32'h0, 32'h0, 5'h00, 32'hfffffffe, 5'h01);
    ex(5'h0d, 2'h0, 32'h2, 32'h0, 32'h9, 5'h00, 32'h0, 5'h01);
    ex(5'h0e, 2'h2, 32'h10100, 32'h0, 32'h0, 5'h04, 32'h8, 5'h00);
    ex(5'h0f, 2'h2, 32'h10100, 32'h0, 32'h0, 5'h04, 32'h10, 5'h00);
    ex(5'h0e, 2'h2, 32'h80000000, 32'h0, 32'h0, 5'h00, 32'h1f, 5'h00);
    ex(5'h0e, 2'h2, 32'h0, 32'h0, 32'h0, 5'h00, 32'h0, 5'h04);
    rd(shift_rotate_pkg::STATUS_OFS, v);
    check("scan found none", v, 32'h2);
  endtask : t_bits
  task automatic t_cond;
    logic [4:0] f;
    for (int i = 0; i < 64; i++) begin
      cc = i[3:0];
      f = PATS[i[5:4]];
      ex(5'h10, 2'h0, 32'habcdef12, 32'h0, 32'h0, f, {24'habcdef, 7'h0, cond_bit(cc, f)}, f);
    end
    cc = 4'h0;
  endtask : t_cond
  task automatic summarize;
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_bus();
    t_shift();
    t_double();
    t_rotate();
    t_bits();
    t_cond();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    summarize();
  end
endmodule : shift_rotate_bit_unit_test
